// >>> hdl/sce_pkg.sv
// constants and types for the scratchpad memory command engine
// How it works
// - write-scratch takes two address bytes, then data stored from low-five offset
// - last whole byte sets ending offset; a broken last byte sets partial flag
// - status byte: authorized flag, zero, partial flag, five-bit ending offset
// - write-scratch CRC from zero; inverted CRC sent when ending offset is 31
// - register page 200h-213h is write protected while a mission runs
// - read-scratch sends address, status, data to end, inverted CRC
// - after read-scratch CRC only ones are sent until bus reset
// - copy needs three bytes matching address low, high, status exactly
// - copy moves scratch offsets start through end to target address
// - after copy alternate one and zero; bus reset ignored while copying
// - copy takes two microseconds per byte
// - authorized flag stays set until the next write-scratch command
// - copying into 200h-213h during a mission stops the mission
// - read-memory takes an address, sends bytes to memory end, then zeros
// - read-memory loads address registers, status byte untouched
// - read-with-CRC sends each page then its inverted CRC, page after page
// - first page CRC covers command and address; later pages only data
// - past memory end zeros are sent with CRCs at page boundaries
// - clear wipes mission settings, alarms, histogram; not log or alarm flags
// - clear runs only if clear enable is set; any command drops enable
// - clear takes 500 us, then memory-cleared reads 1, enable reads 0
// - nonzero sample rate copy starts mission if idle, cleared, enabled
// - regular speed unless fast speed was selected
package sce_pkg;

  localparam logic [7:0]  CMD_WRITE_SCRATCH = 8'h0f;
  localparam logic [7:0]  CMD_READ_SCRATCH  = 8'haa;
  localparam logic [7:0]  CMD_COPY_SCRATCH  = 8'h55;
  localparam logic [7:0]  CMD_READ_MEM      = 8'hf0;
  localparam logic [7:0]  CMD_READ_MEM_CRC  = 8'ha5;
  localparam logic [7:0]  CMD_CLEAR_MEM     = 8'h3c;

  localparam logic [15:0] PROT_LO           = 16'h0200;
  localparam logic [15:0] PROT_HI           = 16'h0213;
  localparam logic [15:0] SAMPLE_RATE_ADDR  = 16'h020d;
  localparam logic [15:0] MEM_TOP_DEF       = 16'h0fff;

  localparam logic [4:0]  SCRATCH_LAST      = 5'h1f;
  localparam logic [2:0]  BIT_LAST          = 3'h7;
  localparam logic [1:0]  IDX_LOW           = 2'h0;
  localparam logic [1:0]  IDX_HIGH          = 2'h1;
  localparam logic [1:0]  IDX_STATUS        = 2'h2;
  localparam logic [1:0]  IDX_DATA          = 2'h3;

  localparam logic [7:0]  FILL_ONES         = 8'hff;
  localparam logic [7:0]  FILL_ALT          = 8'h55;
  localparam logic [7:0]  FILL_ZERO         = 8'h00;
  localparam logic [15:0] CRC_POLY_REV      = 16'ha001;

  localparam int CLK_KHZ   = 25000;
  localparam int COPY_NS   = 2000;
  localparam int COPY_CYC  = (COPY_NS * CLK_KHZ + 999999) / 1000000;
  localparam int CLEAR_US  = 500;
  localparam int CLEAR_CYC = (CLEAR_US * CLK_KHZ + 999) / 1000;

  typedef enum logic [3:0] {
    ST_IDLE, ST_GET_CMD, ST_WS_ADDR, ST_WS_DATA, ST_RS_SEND,
    ST_CP_AUTH, ST_CP_COPY, ST_RM_ADDR, ST_RM_DATA, ST_CRC_OUT,
    ST_ONES, ST_ALT, ST_MUTE
  } sce_state_t;

  typedef struct packed {
    logic       auth;
    logic       zero;
    logic       partial;
    logic [4:0] endOff;
  } sce_status_t;

  typedef struct packed {
    logic stb;
    logic dat;
  } sce_slot_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } sce_memwr_t;

endpackage

// >>> hdl/sce_command_engine.sv
// memory and control command engine behind the serial slot layer
`timescale 1ns/1ns
`default_nettype none
module sce_command_engine
  import sce_pkg::*;
#(
  parameter logic [15:0] MEM_TOP   = MEM_TOP_DEF,
  parameter int          CLEAR_LEN = CLEAR_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire sce_slot_t   slot,
  input  wire logic        busReset,
  input  wire logic        cmdStart,
  input  wire logic [7:0]  memRdData,
  input  wire logic        missionEnable_n,
  input  wire logic        clearEnableBit,
  input  wire logic        fastSpeedReq,
  output logic             txBit,
  output logic             txActive,
  output logic [15:0]      memRdAddr,
  output sce_memwr_t       memWr,
  output logic             clearBusy,
  output logic             clearEnableDrop,
  output logic             missionRunning,
  output logic             memoryCleared,
  output logic             fastSpeed
);

  localparam int CW = $clog2(CLEAR_LEN + 1);
  localparam logic [CW-1:0] CLEAR_LAST = CW'(CLEAR_LEN - 1);
  localparam logic [5:0] COPY_LAST = 6'(COPY_CYC - 1);

  sce_state_t  state_r;
  sce_state_t  after_r;
  logic [2:0]  bitCnt_r;
  logic [7:0]  rxByte_r;
  logic [7:0]  txByte_r;
  logic        txActive_r;
  logic        loadPend_r;
  logic [15:0] crc_r;
  logic        crcSel_r;
  logic [1:0]  byteIdx_r;
  logic [7:0]  tgtLow_r;
  logic [7:0]  tgtHigh_r;
  logic [4:0]  endOff_r;
  logic        partial_r;
  logic        authOk_r;
  logic        authBad_r;
  logic        withCrc_r;
  logic [4:0]  scOff_r;
  logic [15:0] addr_r;
  logic        pastEnd_r;
  logic [5:0]  copyCnt_r;
  sce_memwr_t  memWr_r;
  logic [CW-1:0] clrCnt_r;
  logic        clearBusy_r;
  logic        clearEnableDrop_r;
  logic        missionRunning_r;
  logic        memoryCleared_r;
  logic        fastSpeed_r;
  logic [7:0]  scratch [32];

  logic        sendState;
  logic        crcOn;
  logic        lineBit;
  logic        byteDone;
  logic [7:0]  fullByte;
  logic [15:0] crcNext;
  logic [7:0]  srcByte;
  logic        abort;
  logic        inProt;
  logic        copyFire;
  logic        cmdDecoded;
  logic        clearDone;
  sce_status_t status;

  // bit that the line carries in this slot, ours when sending
  assign sendState = state_r inside {ST_RS_SEND, ST_RM_DATA, ST_CRC_OUT,
                                     ST_ONES, ST_ALT};
  assign crcOn     = state_r inside {ST_GET_CMD, ST_WS_ADDR, ST_WS_DATA,
                                     ST_RM_ADDR, ST_RS_SEND, ST_RM_DATA};
  assign lineBit   = sendState ? txByte_r[0] : slot.dat;
  assign byteDone  = slot.stb && (bitCnt_r == BIT_LAST);
  assign fullByte  = {lineBit, rxByte_r[7:1]};
  assign crcNext   = (crc_r >> 1) ^
                     ((crc_r[0] ^ lineBit) ? CRC_POLY_REV : 16'h0000);
  // a bus reset cannot break into a running copy
  assign abort     = busReset && (state_r != ST_CP_COPY);
  assign inProt    = (addr_r >= PROT_LO) && (addr_r <= PROT_HI);
  assign copyFire  = (state_r == ST_CP_COPY) && (copyCnt_r == COPY_LAST);
  assign cmdDecoded = (state_r == ST_GET_CMD) && byteDone && !abort;
  assign clearDone = clearBusy_r && (clrCnt_r == CLEAR_LAST);
  assign status    = '{auth: authOk_r, zero: 1'b0, partial: partial_r,
                       endOff: endOff_r};

  // next byte to put on the line
  always_comb begin
    srcByte = FILL_ONES;
    unique case (state_r)
      ST_RS_SEND: begin
        unique case (byteIdx_r)
          IDX_LOW:    srcByte = tgtLow_r;
          IDX_HIGH:   srcByte = tgtHigh_r;
          IDX_STATUS: srcByte = status;
          IDX_DATA:   srcByte = scratch[scOff_r];
        endcase
      end
      ST_RM_DATA: srcByte = pastEnd_r ? FILL_ZERO : memRdData;
      ST_CRC_OUT: srcByte = crcSel_r ? ~crc_r[15:8] : ~crc_r[7:0];
      ST_ONES:    srcByte = FILL_ONES;
      ST_ALT:     srcByte = FILL_ALT;
      default:    srcByte = FILL_ONES;
    endcase
  end

  // slot counting and receive shifter
  always_ff @(posedge core_clk) begin
    if (reset || abort || cmdStart) begin
      bitCnt_r <= 3'h0;
      rxByte_r <= FILL_ZERO;
    end else if (slot.stb) begin
      bitCnt_r <= bitCnt_r + 3'h1;
      rxByte_r <= fullByte;
    end
  end

  // crc runs over the bits of the command, address and data states, frozen while it is sent
  always_ff @(posedge core_clk) begin
    if (reset || cmdStart) begin
      crc_r <= 16'h0000;
    end else if (state_r == ST_CRC_OUT && byteDone && crcSel_r) begin
      crc_r <= 16'h0000;
    end else if (slot.stb && crcOn) begin
      crc_r <= crcNext;
    end
  end

  // transmit shifter, loaded a cycle after the source moves
  always_ff @(posedge core_clk) begin
    if (reset || abort) begin
      txByte_r   <= FILL_ONES;
      txActive_r <= 1'b0;
    end else if (loadPend_r) begin
      txByte_r   <= srcByte;
      txActive_r <= sendState;
    end else if (slot.stb && sendState && !byteDone) begin
      txByte_r   <= {1'b1, txByte_r[7:1]};
    end
  end

  // scratchpad storage
  always_ff @(posedge core_clk) begin
    if (state_r == ST_WS_DATA && byteDone && !abort) begin
      scratch[scOff_r] <= fullByte;
    end
  end

  // command sequencer
  always_ff @(posedge core_clk) begin
    loadPend_r <= 1'b0;
    memWr_r.we <= 1'b0;
    if (reset) begin
      state_r   <= ST_IDLE;
      after_r   <= ST_ONES;
      byteIdx_r <= IDX_LOW;
      tgtLow_r  <= FILL_ZERO;
      tgtHigh_r <= FILL_ZERO;
      endOff_r  <= 5'h00;
      partial_r <= 1'b0;
      authOk_r  <= 1'b0;
      authBad_r <= 1'b0;
      withCrc_r <= 1'b0;
      scOff_r   <= 5'h00;
      addr_r    <= 16'h0000;
      pastEnd_r <= 1'b0;
      crcSel_r  <= 1'b0;
      copyCnt_r <= 6'h00;
      memWr_r   <= '0;
    end else if (abort) begin
      if (state_r == ST_WS_DATA && bitCnt_r != 3'h0) begin
        partial_r <= 1'b1;
      end
      state_r <= ST_IDLE;
    end else if (cmdStart && state_r == ST_IDLE) begin
      state_r <= ST_GET_CMD;
    end else begin
      unique case (state_r)
        ST_GET_CMD: if (byteDone) begin
          byteIdx_r <= IDX_LOW;
          loadPend_r <= 1'b1;
          unique case (fullByte)
            CMD_WRITE_SCRATCH: begin
              state_r   <= ST_WS_ADDR;
              authOk_r  <= 1'b0;
              partial_r <= 1'b0;
            end
            CMD_READ_SCRATCH: begin
              state_r <= ST_RS_SEND;
              scOff_r <= tgtLow_r[4:0];
            end
            CMD_COPY_SCRATCH: begin
              state_r   <= ST_CP_AUTH;
              authBad_r <= 1'b0;
            end
            CMD_READ_MEM, CMD_READ_MEM_CRC: begin
              state_r   <= ST_RM_ADDR;
              withCrc_r <= (fullByte == CMD_READ_MEM_CRC);
            end
            default: state_r <= ST_MUTE;
          endcase
        end
        ST_WS_ADDR: if (byteDone) begin
          byteIdx_r <= IDX_HIGH;
          if (byteIdx_r == IDX_LOW) begin
            tgtLow_r <= fullByte;
          end else begin
            tgtHigh_r <= fullByte;
            scOff_r   <= tgtLow_r[4:0];
            state_r   <= ST_WS_DATA;
          end
        end
        ST_WS_DATA: if (byteDone) begin
          endOff_r <= scOff_r;
          if (scOff_r == SCRATCH_LAST) begin
            state_r    <= ST_CRC_OUT;
            after_r    <= ST_ONES;
            crcSel_r   <= 1'b0;
            loadPend_r <= 1'b1;
          end else begin
            scOff_r <= scOff_r + 5'h01;
          end
        end
        ST_RS_SEND: if (byteDone) begin
          loadPend_r <= 1'b1;
          if (byteIdx_r != IDX_DATA) begin
            byteIdx_r <= byteIdx_r + 2'h1;
          end else if (scOff_r == SCRATCH_LAST) begin
            state_r  <= ST_CRC_OUT;
            after_r  <= ST_ONES;
            crcSel_r <= 1'b0;
          end else begin
            scOff_r <= scOff_r + 5'h01;
          end
        end
        ST_CP_AUTH: if (byteDone) begin
          byteIdx_r <= byteIdx_r + 2'h1;
          unique case (byteIdx_r)
            IDX_LOW:  authBad_r <= (fullByte != tgtLow_r);
            IDX_HIGH: authBad_r <= authBad_r || (fullByte != tgtHigh_r);
            default: begin
              if (authBad_r || fullByte != status) begin
                state_r <= ST_MUTE;
              end else begin
                authOk_r  <= 1'b1;
                state_r   <= ST_CP_COPY;
                scOff_r   <= tgtLow_r[4:0];
                addr_r    <= {tgtHigh_r, tgtLow_r};
                copyCnt_r <= 6'h00;
              end
            end
          endcase
        end
        ST_CP_COPY: begin
          if (copyFire) begin
            copyCnt_r    <= 6'h00;
            memWr_r.we   <= !(missionRunning_r && inProt);
            memWr_r.addr <= addr_r;
            memWr_r.data <= scratch[scOff_r];
            if (scOff_r == endOff_r) begin
              state_r    <= ST_ALT;
              loadPend_r <= 1'b1;
            end else begin
              scOff_r <= scOff_r + 5'h01;
              addr_r  <= addr_r + 16'h0001;
            end
          end else begin
            copyCnt_r <= copyCnt_r + 6'h01;
          end
        end
        ST_RM_ADDR: if (byteDone) begin
          byteIdx_r <= IDX_HIGH;
          if (byteIdx_r == IDX_LOW) begin
            tgtLow_r <= fullByte;
          end else begin
            tgtHigh_r  <= fullByte;
            addr_r     <= {fullByte, tgtLow_r};
            pastEnd_r  <= 1'b0;
            state_r    <= ST_RM_DATA;
            loadPend_r <= 1'b1;
          end
        end
        ST_RM_DATA: if (byteDone) begin
          loadPend_r <= 1'b1;
          addr_r     <= addr_r + 16'h0001;
          if (addr_r == MEM_TOP) begin
            pastEnd_r <= 1'b1;
          end
          if (withCrc_r && addr_r[4:0] == SCRATCH_LAST) begin
            state_r  <= ST_CRC_OUT;
            after_r  <= ST_RM_DATA;
            crcSel_r <= 1'b0;
          end
        end
        ST_CRC_OUT: if (byteDone) begin
          loadPend_r <= 1'b1;
          crcSel_r   <= 1'b1;
          if (crcSel_r) begin
            state_r <= after_r;
          end
        end
        // fill patterns reload each byte, or the shifter would run out to all ones
        ST_ONES, ST_ALT: if (byteDone) begin
          loadPend_r <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // clear timer runs on its own so a bus reset cannot cut it short
  always_ff @(posedge core_clk) begin
    clearEnableDrop_r <= 1'b0;
    if (reset) begin
      clearBusy_r <= 1'b0;
      clrCnt_r    <= '0;
    end else begin
      if (cmdDecoded) begin
        clearEnableDrop_r <= 1'b1;
      end
      if (cmdDecoded && fullByte == CMD_CLEAR_MEM && clearEnableBit
          && !clearBusy_r) begin
        clearBusy_r <= 1'b1;
        clrCnt_r    <= '0;
      end else if (clearDone) begin
        clearBusy_r <= 1'b0;
      end else if (clearBusy_r) begin
        clrCnt_r <= clrCnt_r + CW'(1);
      end
    end
  end

  // mission flags; a finished clear wins over a same-cycle start
  always_ff @(posedge core_clk) begin
    if (reset) begin
      missionRunning_r <= 1'b0;
      memoryCleared_r  <= 1'b0;
    end else begin
      if (copyFire && inProt && missionRunning_r) begin
        missionRunning_r <= 1'b0;
      end else if (copyFire && addr_r == SAMPLE_RATE_ADDR
                   && scratch[scOff_r] != FILL_ZERO && !missionRunning_r
                   && memoryCleared_r && !missionEnable_n) begin
        missionRunning_r <= 1'b1;
        memoryCleared_r  <= 1'b0;
      end
      if (clearDone) begin
        memoryCleared_r <= 1'b1;
      end
    end
  end

  // speed follows the explicit request only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fastSpeed_r <= 1'b0;
    end else begin
      fastSpeed_r <= fastSpeedReq;
    end
  end

  assign txBit           = txByte_r[0];
  assign txActive        = txActive_r;
  assign memRdAddr       = addr_r;
  assign memWr           = memWr_r;
  assign clearBusy       = clearBusy_r;
  assign clearEnableDrop = clearEnableDrop_r;
  assign missionRunning  = missionRunning_r;
  assign memoryCleared   = memoryCleared_r;
  assign fastSpeed       = fastSpeed_r;

  // cycles since the last memory write, parked at its top value
  logic [5:0]  weGap_r;
  always_ff @(posedge core_clk) begin
    if (reset || memWr_r.we) begin
      weGap_r <= 6'h00;
    end else if (weGap_r != '1) begin
      weGap_r <= weGap_r + 6'h01;
    end
  end

  a_partial_on_cut: assert property (@(posedge core_clk) disable iff (reset)
    busReset && state_r == ST_WS_DATA && bitCnt_r != 3'h0 |=> partial_r)
    else $error("partial flag missed");
  a_auth_cleared: assert property (@(posedge core_clk) disable iff (reset)
    cmdDecoded && fullByte == CMD_WRITE_SCRATCH |=> !authOk_r)
    else $error("authorized flag kept");
  a_protect_page: assert property (@(posedge core_clk) disable iff (reset)
    copyFire && inProt && missionRunning_r |=> !memWr_r.we && !missionRunning_r)
    else $error("protected write or mission kept");
  a_copy_no_abort: assert property (@(posedge core_clk) disable iff (reset)
    state_r == ST_CP_COPY && busReset |=> state_r inside {ST_CP_COPY, ST_ALT})
    else $error("copy aborted");
  a_copy_pace: assert property (@(posedge core_clk) disable iff (reset)
    memWr_r.we |-> (weGap_r == COPY_LAST) || (weGap_r == '1))
    else $error("copy byte spacing");
  a_clear_done: assert property (@(posedge core_clk) disable iff (reset)
    $fell(clearBusy_r) |-> memoryCleared_r)
    else $error("memory cleared not set");
  a_drop_enable: assert property (@(posedge core_clk) disable iff (reset)
    cmdDecoded |=> clearEnableDrop_r ##1 !clearEnableDrop_r)
    else $error("clear enable not dropped");
  a_mute_line: assert property (@(posedge core_clk) disable iff (reset)
    state_r == ST_MUTE && !loadPend_r |-> !txActive_r && txByte_r == FILL_ONES)
    else $error("line driven on unknown command");
  a_zero_past_end: assert property (@(posedge core_clk) disable iff (reset)
    loadPend_r && state_r == ST_RM_DATA && pastEnd_r |=> txByte_r == FILL_ZERO)
    else $error("nonzero past memory end");
  a_speed_default: assert property (@(posedge core_clk)
    reset |=> !fastSpeed_r)
    else $error("fast speed after reset");

endmodule
`default_nettype wire

// >>> tb/sce_master_model.sv
// bus master model driving the slot stream of the engine
`timescale 1ns/1ns
`default_nettype none
module sce_master_model
  import sce_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic txBit,
  output sce_slot_t slot,
  output logic      busReset,
  output logic      cmdStart
);
  // line idles high through the bus pull-up
  initial begin
    slot = '{stb: 1'b0, dat: 1'b1};
    busReset = 1'b0;
    cmdStart = 1'b0;
  end
  // reset pulse opens every transaction
  task automatic bus_rst();
    @(posedge core_clk);
    busReset <= 1'b1;
    @(posedge core_clk);
    busReset <= 1'b0;
  endtask
  // n slots lsb first, four cycles apart; line sampled before each slot
  task automatic xfer(input logic [7:0] w, input int n,
                      output logic [7:0] r);
    r = 8'hff;
    for (int i = 0; i < n; i++) begin
      repeat (3) @(posedge core_clk);
      r[i] = txBit;
      slot <= '{stb: 1'b1, dat: w[i]};
      @(posedge core_clk);
      slot <= '{stb: 1'b0, dat: 1'b1};
    end
  endtask
  // command code right after selection, regular speed only
  task automatic cmd(input logic [7:0] c);
    logic [7:0] d;
    @(posedge core_clk);
    cmdStart <= 1'b1;
    @(posedge core_clk);
    cmdStart <= 1'b0;
    xfer(c, 8, d);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the command engine
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sce_pkg::*;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  exp0;
    logic [7:0]  exp1;
  } sce_row_t;
  sce_slot_t   slot;
  sce_memwr_t  memWr;
  logic [15:0] memRdAddr, crc, wA[0:31];
  logic [7:0]  memRdData, b, wD[0:31];
  logic        core_clk, reset, busReset, cmdStart, txBit, txActive;
  logic        clearBusy, clearEnableDrop, missionRunning, memoryCleared;
  logic        fastSpeed, missionEnable_n, fastSpeedReq, ceSet;
  logic        clearEnableBit = 1'b0;
  int          failures = 0, num_checks = 0, cyc = 0, wrN = 0, base;
  int          wT[0:31];
  // read-memory rows: start address, first two bytes expected
  sce_row_t    rows[3] = '{'{16'h0010, 8'h10, 8'h11},
                           '{16'h0123, 8'h22, 8'h25},
                           '{16'h0fff, 8'hf0, 8'h00}};
  // memory pattern: low address byte xor high address byte
  assign memRdData = memRdAddr[7:0] ^ memRdAddr[15:8];
  sce_command_engine #(.CLEAR_LEN(20)) i_sce_command_engine (
    .core_clk(core_clk), .reset(reset), .slot(slot),
    .busReset(busReset), .cmdStart(cmdStart), .memRdData(memRdData),
    .missionEnable_n(missionEnable_n), .clearEnableBit(clearEnableBit),
    .fastSpeedReq(fastSpeedReq), .txBit(txBit), .txActive(txActive),
    .memRdAddr(memRdAddr), .memWr(memWr), .clearBusy(clearBusy),
    .clearEnableDrop(clearEnableDrop), .missionRunning(missionRunning),
    .memoryCleared(memoryCleared), .fastSpeed(fastSpeed));
  sce_master_model i_sce_master_model (
    .core_clk(core_clk), .txBit(txBit), .slot(slot),
    .busReset(busReset), .cmdStart(cmdStart));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // control register bit: set by bench, dropped by engine
  always @(posedge core_clk) begin
    if (ceSet) clearEnableBit <= 1'b1;
    else if (clearEnableDrop === 1'b1) clearEnableBit <= 1'b0;
  end
  // write log with cycle stamps; one block so stamp and count never race
  always @(posedge core_clk) begin
    if (memWr.we === 1'b1) begin
      wA[wrN] = memWr.addr;
      wD[wrN] = memWr.data;
      wT[wrN] = cyc;
      wrN++;
    end
    // hang guard, well above the whole sequence
    cyc++;
    if (cyc == 30000) begin
      failures++;
      complete_run();
    end
  end
  task automatic check(input string nm, input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // reflected crc16, zero start, lsb first
  function automatic logic [15:0] crc8(input logic [15:0] c,
                                       input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ v[i]) ? (c >> 1) ^ CRC_POLY_REV : c >> 1;
    return c;
  endfunction
  // byte tasks fold expected values into the running crc
  task automatic wr(input logic [7:0] v);
    logic [7:0] d;
    i_sce_master_model.xfer(v, 8, d);
    crc = crc8(crc, v);
  endtask
  task automatic rd(input string nm, input logic [7:0] e);
    logic [7:0] d;
    i_sce_master_model.xfer(8'hff, 8, d);
    check(nm, d, e);
    crc = crc8(crc, e);
  endtask
  task automatic go(input logic [7:0] c);
    i_sce_master_model.bus_rst();
    i_sce_master_model.cmd(c);
    crc = crc8(16'h0000, c);
  endtask
  // inverted crc low byte first, generator restarts after
  task automatic rdcrc();
    logic [15:0] e;
    e = ~crc;
    rd("crc low", e[7:0]);
    rd("crc high", e[15:8]);
    crc = 16'h0000;
  endtask
  task automatic ws(input logic [15:0] a, input int n);
    go(CMD_WRITE_SCRATCH);
    wr(a[7:0]);
    wr(a[15:8]);
    for (int k = 0; k < n; k++) wr(8'ha0 + 8'(k));
  endtask
  // fixed wait: 50 cycles per byte plus margin; a reset pulse lands mid-copy
  task automatic cp(input logic [15:0] a, input logic [7:0] es, int n);
    base = wrN;
    go(CMD_COPY_SCRATCH);
    wr(a[7:0]);
    wr(a[15:8]);
    wr(es);
    repeat (20) @(posedge core_clk);
    i_sce_master_model.bus_rst();
    repeat (50 * n + 20) @(posedge core_clk);
  endtask
  task automatic tdone(input string nm);
    $display("test %s done", nm);
  endtask
  initial begin
    reset = 1'b1;
    ceSet = 1'b0;
    missionEnable_n = 1'b0;
    fastSpeedReq = 1'b0;
    repeat (12) @(posedge core_clk);
    check("idle txBit", txBit, 1'b1);
    check("idle txActive", txActive, 1'b0);
    check("mission at reset", missionRunning, 1'b0);
    reset <= 1'b0;
    tdone("reset");
    foreach (rows[i]) begin
      go(CMD_READ_MEM);
      wr(rows[i].addr[7:0]);
      wr(rows[i].addr[15:8]);
      rd("mem byte 0", rows[i].exp0);
      rd("mem byte 1", rows[i].exp1);
      tdone("read memory row");
    end
    go(CMD_READ_SCRATCH);
    rd("addr low", 8'hff);
    rd("addr high", 8'h0f);
    rd("status kept", 8'h00);
    ws(16'h013c, 4);
    rdcrc();
    go(CMD_READ_SCRATCH);
    rd("addr low", 8'h3c);
    rd("addr high", 8'h01);
    rd("status", 8'h1f);
    for (int k = 0; k < 4; k++) rd("scratch", 8'ha0 + 8'(k));
    rdcrc();
    rd("ones fill", FILL_ONES);
    tdone("scratch write and read");
    cp(16'h013c, 8'h1f, 4);
    check("copy count", 16'(wrN - base), 16'h4);
    check("copy first", wA[base], 16'h013c);
    check("copy last data", wD[base + 3], 8'ha3);
    check("copy gap", 16'(wT[base + 1] - wT[base]), 16'd50);
    for (int k = 0; k < 2; k++) rd("alternating", FILL_ALT);
    go(CMD_READ_SCRATCH);
    rd("addr low", 8'h3c);
    rd("addr high", 8'h01);
    rd("status auth", 8'h9f);
    cp(16'h013c, 8'h1e, 1);
    check("bad auth copy", 16'(wrN - base), 16'h0);
    check("bad auth mute", txActive, 1'b0);
    tdone("copy");
    go(CMD_CLEAR_MEM);
    repeat (4) @(posedge core_clk);
    check("clear not enabled", clearBusy, 1'b0);
    i_sce_master_model.bus_rst();
    ceSet <= 1'b1;
    @(posedge core_clk);
    ceSet <= 1'b0;
    i_sce_master_model.cmd(CMD_CLEAR_MEM);
    repeat (4) @(posedge core_clk);
    check("clear busy", clearBusy, 1'b1);
    repeat (30) @(posedge core_clk);
    check("clear done", clearBusy, 1'b0);
    check("cleared flag", memoryCleared, 1'b1);
    check("enable dropped", clearEnableBit, 1'b0);
    tdone("clear");
    ws(SAMPLE_RATE_ADDR, 1);
    cp(SAMPLE_RATE_ADDR, 8'h0d, 1);
    check("mission start", missionRunning, 1'b1);
    check("cleared dropped", memoryCleared, 1'b0);
    ws(PROT_LO, 1);
    cp(PROT_LO, 8'h00, 1);
    check("protected write", 16'(wrN - base), 16'h0);
    check("mission stopped", missionRunning, 1'b0);
    tdone("mission");
    go(CMD_READ_MEM_CRC);
    wr(8'hfe);
    wr(8'h01);
    rd("page tail 0", 8'hff);
    rd("page tail 1", 8'hfe);
    rdcrc();
    rd("next page", 8'h02);
    tdone("read with crc");
    go(8'h99);
    rd("unknown line", 8'hff);
    check("unknown mute", txActive, 1'b0);
    ws(16'h0040, 1);
    i_sce_master_model.xfer(8'h00, 3, b);
    go(CMD_READ_SCRATCH);
    rd("addr low", 8'h40);
    rd("addr high", 8'h00);
    rd("partial status", 8'h20);
    tdone("partial byte");
    fastSpeedReq <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("fast speed", fastSpeed, 1'b1);
    tdone("speed");
    complete_run();
  end
endmodule
`default_nettype wire
